// [dbgci_pkg.sv]
package dbgci_pkg;

   // ----------------------------------------
   // Command codes
   // ----------------------------------------
   localparam logic [7:0]  CMD_RD_RUNTIME = 8'h03;
   localparam logic [7:0]  CMD_WR_CTL     = 8'h04;
   localparam logic [7:0]  CMD_RD_CTL     = 8'h05;
   localparam logic [7:0]  CMD_WR_PC      = 8'h06;
   localparam logic [7:0]  CMD_RD_PC      = 8'h07;
   localparam logic [7:0]  CMD_WR_REG     = 8'h08;

   // ----------------------------------------
   // Fields, reset values and counts
   // ----------------------------------------
   localparam int          CTL_MODE_BIT   = 7;
   localparam logic [7:0]  CTL_RESET      = 8'h00;
   localparam logic [15:0] PC_BLOCKED     = 16'hFFFF;
   localparam logic [11:0] FLASH_CTL_LO   = 12'hFF8;
   localparam logic [11:0] FLASH_CTL_HI   = 12'hFFF;
   localparam int          FIFO_DEPTH     = 8;
   localparam int          BYTE_W         = 8;
   localparam logic [1:0]  TX_TWO         = 2'h2;
   localparam logic [1:0]  TX_ONE         = 2'h1;

   // ----------------------------------------
   // Carriers
   // ----------------------------------------
   typedef struct packed {
      logic        valid;
      logic [11:0] addr;
      logic [7:0]  data;
   } dbgci_regwr_t;

   typedef struct packed {
      logic        valid;
      logic [15:0] value;
   } dbgci_pcwr_t;

   typedef struct packed {
      logic       valid;
      logic [7:0] data;
   } dbgci_byte_t;

   typedef enum logic [8:0] {
      ST_IDLE = 9'h001,
      ST_CTLW = 9'h002,
      ST_PCHI = 9'h004,
      ST_PCLO = 9'h008,
      ST_ADHI = 9'h010,
      ST_ADLO = 9'h020,
      ST_SIZE = 9'h040,
      ST_DATA = 9'h080,
      ST_SEND = 9'h100
   } dbgci_state_t;

endpackage : dbgci_pkg

// [dbgci_core.sv]
`timescale 1ns/100ps

// ----------------------------------------
// Byte FIFO between the pin receiver and the parser
// ----------------------------------------
module dbgci_fifo
   import dbgci_pkg::*;
#(
   parameter int WIDTH = BYTE_W,
   parameter int DEPTH = FIFO_DEPTH
) (
   input  wire logic             clk,
   input  wire logic             resetn,
   input  wire logic             inValid,
   input  wire logic [WIDTH-1:0] inData,
   output      logic             inReady,
   output      logic             outValid,
   output      logic [WIDTH-1:0] outData,
   input  wire logic             outReady
);
   localparam int AW = $clog2(DEPTH);

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0]               wp;
      logic [AW-1:0]               rp;
      logic [AW:0]                 cnt;
      logic                        ready;
   } dbgci_fifo_state_t;

   dbgci_fifo_state_t s_r;
   dbgci_fifo_state_t s_nxt;
   logic              push;
   logic              pop;

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   // Wrap by compare, so a depth that is not a power of two still works
   function automatic logic [AW-1:0] nextPtr(input logic [AW-1:0] p);
      nextPtr = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
   endfunction : nextPtr

   // Ready is registered so the source sees a flop, at the cost of one
   // cycle of slack when the last slot frees up
   always_comb begin
      s_nxt = s_r;
      push  = inValid && s_r.ready;
      pop   = outValid && outReady;
      if (push) begin
         s_nxt.mem[s_r.wp] = inData;
         s_nxt.wp          = nextPtr(s_r.wp);
      end
      if (pop) begin
         s_nxt.rp = nextPtr(s_r.rp);
      end
      s_nxt.cnt   = s_r.cnt + (AW + 1)'(push) - (AW + 1)'(pop);
      s_nxt.ready = (s_nxt.cnt != (AW + 1)'(DEPTH));
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         // Empty after reset, so the receiver may push at once
         s_r       <= '0;
         s_r.ready <= 1'b1;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign inReady  = s_r.ready;
   assign outValid = (s_r.cnt != '0);
   assign outData  = s_r.mem[s_r.rp];

endmodule : dbgci_fifo

// ----------------------------------------
// Command interpreter
// ----------------------------------------
module dbgci_core
   import dbgci_pkg::*;
#(
   parameter logic [11:0] FLASH_LO = FLASH_CTL_LO,
   parameter logic [11:0] FLASH_HI = FLASH_CTL_HI,
   parameter int          DEPTH    = FIFO_DEPTH
) (
   input  wire logic         clk,
   input  wire logic         resetn,
   input  wire dbgci_byte_t  rxByte,
   output      logic         rxReady,
   output      dbgci_byte_t  txByte,
   input  wire logic         txReady,
   input  wire logic         readProtect,
   input  wire logic [15:0]  pcValue,
   input  wire logic [15:0]  runTimeCount,
   output      dbgci_pcwr_t  pcWrite,
   output      dbgci_regwr_t regWrite,
   output      logic [7:0]   debugCtl
);

   typedef struct packed {
      dbgci_state_t state;
      logic [7:0]   ctl;
      logic [7:0]   hold;
      logic [11:0]  addr;
      logic [8:0]   left;
      logic [15:0]  txBuf;
      logic [1:0]   txLeft;
      dbgci_byte_t  tx;
      dbgci_pcwr_t  pcw;
      dbgci_regwr_t rw;
   } dbgci_core_state_t;

   dbgci_core_state_t s_r;
   dbgci_core_state_t s_nxt;
   logic              popValid;
   logic [7:0]        popData;
   logic              popReady;
   logic              debugMode;

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   function automatic logic inFlashCtl(input logic [11:0] a);
      inFlashCtl = (a >= FLASH_LO) && (a <= FLASH_HI);
   endfunction : inFlashCtl

   // Same gate for PC writes and reads, kept in one place
   function automatic logic pcOpen(input logic mode, input logic prot);
      pcOpen = mode && !prot;
   endfunction : pcOpen

   // ----------------------------------------
   // Receive buffer
   // ----------------------------------------
   dbgci_fifo #(
      .WIDTH (BYTE_W),
      .DEPTH (DEPTH)
   ) u_fifo (
      .clk      (clk),
      .resetn   (resetn),
      .inValid  (rxByte.valid),
      .inData   (rxByte.data),
      .inReady  (rxReady),
      .outValid (popValid),
      .outData  (popData),
      .outReady (popReady)
   );

   assign debugMode = s_r.ctl[CTL_MODE_BIT];
   // Parser stalls while a reply is pending, so a slow host backs up the FIFO
   assign popReady  = (s_r.state != ST_SEND);

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb begin
      s_nxt           = s_r;
      s_nxt.pcw.valid = 1'b0;
      s_nxt.rw.valid  = 1'b0;
      if (s_r.tx.valid && txReady) begin
         s_nxt.tx.valid = 1'b0;
      end
      unique case (s_r.state)
         ST_IDLE: begin
            if (popValid) begin
               unique case (popData)
                  CMD_WR_CTL: s_nxt.state = ST_CTLW;
                  CMD_WR_PC:  s_nxt.state = ST_PCHI;
                  CMD_WR_REG: s_nxt.state = ST_ADHI;
                  CMD_RD_CTL: begin
                     s_nxt.txBuf  = {s_r.ctl, 8'h00};
                     s_nxt.txLeft = TX_ONE;
                     s_nxt.state  = ST_SEND;
                  end
                  CMD_RD_PC: begin
                     // Real PC only when it may be seen
                     s_nxt.txBuf  = pcOpen(debugMode, readProtect) ? pcValue
                                                                   : PC_BLOCKED;
                     s_nxt.txLeft = TX_TWO;
                     s_nxt.state  = ST_SEND;
                  end
                  CMD_RD_RUNTIME: begin
                     s_nxt.txBuf  = runTimeCount;
                     s_nxt.txLeft = TX_TWO;
                     s_nxt.state  = ST_SEND;
                  end
                  // Unknown codes are dropped and take no operands
                  default: s_nxt.state = ST_IDLE;
               endcase
            end
         end
         // ----------------------------------------
         // Operand bytes
         // ----------------------------------------
         ST_CTLW: begin
            if (popValid) begin
               s_nxt.ctl = popData;
               // While readProtect is high the mode bit is sticky: a write can set it but not clear it
               if (readProtect) begin
                  s_nxt.ctl[CTL_MODE_BIT] = s_r.ctl[CTL_MODE_BIT] | popData[CTL_MODE_BIT];
               end
               s_nxt.state = ST_IDLE;
            end
         end
         ST_PCHI: begin
            if (popValid) begin
               s_nxt.hold  = popData;
               s_nxt.state = ST_PCLO;
            end
         end
         ST_PCLO: begin
            if (popValid) begin
               s_nxt.pcw.value = {s_r.hold, popData};
               s_nxt.pcw.valid = pcOpen(debugMode, readProtect);
               s_nxt.state     = ST_IDLE;
            end
         end
         ST_ADHI: begin
            if (popValid) begin
               // Upper nibble of this byte is zero by protocol and is ignored
               s_nxt.addr[11:8] = popData[3:0];
               s_nxt.state      = ST_ADLO;
            end
         end
         ST_ADLO: begin
            if (popValid) begin
               s_nxt.addr[7:0] = popData;
               s_nxt.state     = ST_SIZE;
            end
         end
         ST_SIZE: begin
            if (popValid) begin
               // Nine-bit count, so a zero size runs a full 256 bytes
               s_nxt.left  = {(popData == 8'h00), popData};
               s_nxt.state = ST_DATA;
            end
         end
         ST_DATA: begin
            if (popValid) begin
               s_nxt.rw.addr  = s_r.addr;
               s_nxt.rw.data  = popData;
               // Dropped bytes still count down, so the framing stays in step
               s_nxt.rw.valid = debugMode && (!readProtect || inFlashCtl(s_r.addr));
               // Address wraps inside the 12-bit register space
               s_nxt.addr     = s_r.addr + 12'h001;
               s_nxt.left     = s_r.left - 9'h001;
               if (s_r.left == 9'h001) begin
                  s_nxt.state = ST_IDLE;
               end
            end
         end
         // ----------------------------------------
         // Reply bytes
         // ----------------------------------------
         ST_SEND: begin
            if (!s_r.tx.valid || txReady) begin
               s_nxt.tx.valid = 1'b1;
               s_nxt.tx.data  = s_r.txBuf[15:8];
               s_nxt.txBuf    = {s_r.txBuf[7:0], 8'h00};
               s_nxt.txLeft   = s_r.txLeft - 2'h1;
               if (s_r.txLeft == TX_ONE) begin
                  s_nxt.state = ST_IDLE;
               end
            end
         end
      endcase
   end

   // ----------------------------------------
   // State register
   // ----------------------------------------
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         s_r       <= '0;
         s_r.state <= ST_IDLE;
         // Debug mode is off after any reset, protected or not
         s_r.ctl   <= CTL_RESET;
      end else begin
         s_r <= s_nxt;
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   assign txByte   = s_r.tx;
   assign pcWrite  = s_r.pcw;
   assign regWrite = s_r.rw;
   assign debugCtl = s_r.ctl;

endmodule : dbgci_core

// [dbgci_monitor.sv]
`timescale 1ns/100ps
module dbgci_monitor
   import dbgci_pkg::*;
(
   input wire logic         clk,
   input wire logic         resetn,
   input wire dbgci_byte_t  rxByte,
   input wire logic         rxReady,
   input wire dbgci_byte_t  txByte,
   input wire logic         txReady,
   input wire logic         readProtect,
   input wire logic [15:0]  pcValue,
   input wire logic [15:0]  runTimeCount,
   input wire dbgci_pcwr_t  pcWrite,
   input wire dbgci_regwr_t regWrite,
   input wire logic [7:0]   debugCtl
);
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);
   sequence s_stall;
      txByte.valid && !txReady;
   endsequence
   sequence s_beats;
      regWrite.valid ##1 regWrite.valid;
   endsequence
   a_reply_held: assert property (s_stall |=> txByte.valid && $stable(txByte.data))
      else $error("reply byte moved while stalled");
   a_mode_sticky: assert property (readProtect && debugCtl[7] |=> debugCtl[7])
      else $error("debug mode cleared under protection");
   a_pc_gate: assert property (pcWrite.valid |-> debugCtl[7] && !readProtect)
      else $error("pc written outside debug or protected");
   a_pc_pulse: assert property (pcWrite.valid |=> !pcWrite.valid)
      else $error("pc write longer than one cycle");
   a_reg_gate: assert property (regWrite.valid |-> debugCtl[7])
      else $error("register written outside debug");
   a_reg_flash: assert property (regWrite.valid && readProtect |-> regWrite.addr >= FLASH_CTL_LO)
      else $error("protected write outside flash control");
   a_addr_step: assert property (s_beats |-> regWrite.addr == $past(regWrite.addr) + 12'h001)
      else $error("burst address did not step");
   a_ctl_apart: assert property ($changed(debugCtl) |-> !pcWrite.valid && !regWrite.valid)
      else $error("control changed with another write");
   a_reset_ctl: assert property ($rose(resetn) |-> rxReady && debugCtl == CTL_RESET)
      else $error("control not cleared by reset");
endmodule : dbgci_monitor

bind dbgci_core dbgci_monitor mon (
   .clk          (clk),
   .resetn       (resetn),
   .rxByte       (rxByte),
   .rxReady      (rxReady),
   .txByte       (txByte),
   .txReady      (txReady),
   .readProtect  (readProtect),
   .pcValue      (pcValue),
   .runTimeCount (runTimeCount),
   .pcWrite      (pcWrite),
   .regWrite     (regWrite),
   .debugCtl     (debugCtl)
);

// [dbgci_host.sv]
`timescale 1ns/100ps
module dbgci_host
   import dbgci_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rxReady,
   output      dbgci_byte_t rxByte,
   input  wire dbgci_byte_t txByte,
   output      logic        txReady
);
   int          stall = 0;
   logic        took;
   logic        got;
   logic [7:0]  gotData;
   initial begin
      rxByte = '0;
      txReady = 1'b0;
   end
   // Handshakes seen with pre-edge values, so no race with the design
   always @(posedge clk) begin
      took <= rxByte.valid && rxReady;
      got <= txByte.valid && txReady;
      gotData <= txByte.data;
   end
   // Operands follow the command in order, high byte first
   task automatic send(input logic [7:0] b, output bit ok);
      rxByte <= {1'b1, b};
      ok = 1'b0;
      for (int w = 0; w < 200 && !ok; w++) begin
         @(posedge clk);
         #1 ok = took;
      end
   endtask : send
   // Released line shows the inverse, so stale data never looks valid
   task automatic idle;
      rxByte <= {1'b0, ~rxByte.data};
      @(posedge clk);
      #1;
   endtask : idle
   task automatic recv(output logic [7:0] d, output bit ok);
      ok = 1'b0;
      for (int w = 0; w < 200 && !ok; w++) begin
         txReady <= (w >= stall);
         @(posedge clk);
         #1 ok = got;
      end
      d = gotData;
   endtask : recv
endmodule : dbgci_host

// [test_debug_command_interpreter.sv]
`timescale 1ns/100ps
module test_debug_command_interpreter;
   import dbgci_pkg::*;
   logic         clk = 1'b0;
   logic         resetn = 1'b0;
   logic         readProtect = 1'b0;
   logic         fullSeen = 1'b0;
   logic [15:0]  pcValue = 16'h1357;
   logic [15:0]  runTimeCount = 16'h2468;
   logic         rxReady;
   logic         txReady;
   logic [7:0]   debugCtl;
   logic [15:0]  lastPc;
   dbgci_byte_t  rxByte;
   dbgci_byte_t  txByte;
   dbgci_pcwr_t  pcWrite;
   dbgci_regwr_t regWrite;
   int           n_errors = 0;
   int           n_compared = 0;
   int           nPc = 0;
   logic [19:0]  wr[$];
   logic [7:0]   q[$];
   always #20 clk = ~clk;
   dbgci_core dut (.clk(clk), .resetn(resetn), .rxByte(rxByte), .rxReady(rxReady),
      .txByte(txByte), .txReady(txReady), .readProtect(readProtect),
      .pcValue(pcValue), .runTimeCount(runTimeCount), .pcWrite(pcWrite),
      .regWrite(regWrite), .debugCtl(debugCtl));
   dbgci_host host (.clk(clk), .rxReady(rxReady), .rxByte(rxByte), .txByte(txByte),
      .txReady(txReady));
   always @(posedge clk) begin
      if (pcWrite.valid === 1'b1) nPc <= nPc + 1;
      if (pcWrite.valid === 1'b1) lastPc <= pcWrite.value;
      if (regWrite.valid === 1'b1) wr.push_back({regWrite.addr, regWrite.data});
      if (rxReady === 1'b0) fullSeen <= 1'b1;
   end
   task stop_test;
      $display("errors %0d, compared %0d", n_errors, n_compared);
      if (n_errors == 0 && n_compared > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : stop_test
   task chk(input string what, input logic [19:0] seen, input logic [19:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_errors++;
         $display("unexpected %s: expected %h, seen %h", what, exp, seen);
      end
   endtask : chk
   task automatic cmd(input logic [7:0] b[$]);
      bit ok;
      foreach (b[i]) begin
         host.send(b[i], ok);
         if (!ok) chk("byte taken", 20'h00000, 20'h00001);
         if (!ok) stop_test();
      end
      host.idle();
   endtask : cmd
   task automatic rx(input string what, input logic [7:0] exp);
      logic [7:0] v;
      bit         ok;
      host.recv(v, ok);
      if (!ok) chk("reply", 20'h00000, 20'h00001);
      if (!ok) stop_test();
      chk(what, v, exp);
   endtask : rx
   task automatic settle;
      repeat (6) @(posedge clk);
      #1;
   endtask : settle
   task automatic t_off;
      cmd('{CMD_WR_CTL, 8'h5A});
      cmd('{8'h09, CMD_RD_CTL}); // Unknown code ahead is dropped
      rx("ctl read", 8'h5A);
      chk("ctl", debugCtl, 8'h5A);
      cmd('{CMD_WR_PC, 8'h12, 8'h34});
      cmd('{CMD_RD_PC});
      rx("pc hi", 8'hFF);
      rx("pc lo", 8'hFF);
      cmd('{CMD_WR_REG, 8'h01, 8'h00, 8'h01, 8'h77});
      settle();
      chk("pc writes", 20'(nPc), 20'h00000);
      chk("reg writes", 20'(wr.size()), 20'h00000);
   endtask : t_off
   task automatic t_on;
      cmd('{CMD_WR_CTL, 8'h80});
      cmd('{CMD_WR_PC, 8'hAB, 8'hCD});
      settle();
      chk("pc value", lastPc, 16'hABCD);
      host.stall = 3;
      cmd('{CMD_RD_PC});
      rx("pc hi", 8'h13);
      rx("pc lo", 8'h57);
      cmd('{CMD_RD_RUNTIME});
      rx("rt hi", 8'h24);
      rx("rt lo", 8'h68);
   endtask : t_on
   task automatic t_burst;
      q = '{CMD_WR_REG, 8'h01, 8'h23, 8'h00};
      for (int i = 0; i < 256; i++) q.push_back(8'(i));
      cmd(q);
      settle();
      chk("burst len", 20'(wr.size()), 20'h00100);
      foreach (wr[i]) chk("beat", wr[i], {12'h123 + 12'(i), 8'(i)});
      wr.delete();
   endtask : t_burst
   // Slow host lets the buffer fill until it refuses
   task automatic t_full;
      host.stall = 40;
      pcValue = 16'h9BDF;
      fork
         cmd('{CMD_RD_PC, 8'h05, 8'h05, 8'h05, 8'h05, 8'h05, 8'h05, 8'h05, 8'h05, 8'h05});
         begin
            rx("pc hi", 8'h9B);
            rx("pc lo", 8'hDF);
            repeat (9) rx("ctl read", 8'h80);
         end
      join
      host.stall = 0;
      chk("refused", fullSeen, 20'h00001);
   endtask : t_full
   task automatic t_prot;
      readProtect = 1'b1;
      cmd('{CMD_WR_CTL, 8'h03});
      settle();
      chk("ctl", debugCtl, 8'h83);
      cmd('{CMD_WR_PC, 8'h55, 8'h66});
      cmd('{CMD_RD_PC});
      rx("pc hi", 8'hFF);
      rx("pc lo", 8'hFF);
      cmd('{CMD_WR_REG, 8'h0F, 8'hF6, 8'h03, 8'hA1, 8'hA2, 8'hA3});
      settle();
      chk("pc writes", 20'(nPc), 20'h00001);
      chk("reg writes", 20'(wr.size()), 20'h00001);
      chk("flash write", wr[0], 20'hFF8A3);
      resetn = 1'b0;
      settle();
      resetn = 1'b1;
      readProtect = 1'b0;
      chk("ctl reset", debugCtl, 8'h00);
      chk("ready after reset", rxReady, 20'h00001);
   endtask : t_prot
   initial begin
      repeat (12) @(posedge clk);
      #1 resetn = 1'b1;
      t_off();
      t_on();
      t_burst();
      t_full();
      t_prot();
      stop_test();
   end
endmodule : test_debug_command_interpreter
